/* File: design/nvs_host.sv */
/*
  Host controller driving a byte-wide battery-backed SRAM through its pins.
  Assumes the memory pins are asynchronous; supply_ok comes from a monitor.
*/
`timescale 1ns/10ps
`default_nettype none
module nvs_host
  import nvsram_pkg::*;
#(
  parameter int POWERUP_CYCLES = POWERUP_CYC
)
(
  input  wire logic                          ref_clk,
  input  wire logic                          rst_b,
  input  wire logic                          supply_ok,
  input  wire logic                          req_valid,
  input  wire logic                          req_write,
  input  wire logic [nvsram_pkg::ADDR_W-1:0] req_addr,
  input  wire logic [nvsram_pkg::DATA_W-1:0] req_wdata,
  output var  logic                          req_ready,
  output var  logic                          rsp_valid,
  output var  logic [nvsram_pkg::DATA_W-1:0] rsp_rdata,
  output var  logic [nvsram_pkg::ADDR_W-1:0] byte_addr,
  output var  logic                          select_n,
  output var  logic                          write_strobe_n,
  output var  logic                          output_gate_n,
  input  wire logic [nvsram_pkg::DATA_W-1:0] byte_bus_in,
  output var  logic [nvsram_pkg::DATA_W-1:0] byte_bus_out,
  output var  logic                          byte_bus_oe
);
  import nvsram_pkg::*;

  localparam logic [TMR_W-1:0] RD_CNT  = TMR_W'(ACCESS_CYC > GATE_CYC ? ACCESS_CYC : GATE_CYC);
  localparam logic [TMR_W-1:0] WR_CNT  = TMR_W'(WRITE_CYC);
  localparam logic [TMR_W-1:0] REC_CNT = TMR_W'(RECOVERY_CYC);
  localparam logic [TMR_W-1:0] ONE_CNT = TMR_W'(1);

  nvs_state_type             state_q;
  logic                      ok_meta_q;
  logic                      ok_q;
  logic [DATA_W-1:0]         din_meta_q;
  logic [DATA_W-1:0]         din_q;
  logic [31:0]               pwr_cnt_q;
  logic                      pwr_good_q;
  logic                      wr_q;
  nvs_tmr_if                 tif ();

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  // Supply monitor and data pins are asynchronous to ref_clk
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ok_meta_q  <= 1'b0;
      ok_q       <= 1'b0;
      din_meta_q <= '0;
      din_q      <= '0;
    end
    else
    begin
      ok_meta_q  <= supply_ok;
      ok_q       <= ok_meta_q;
      din_meta_q <= byte_bus_in;
      din_q      <= din_meta_q;
    end
  end

  // ---------------------------------------------------------------
  // Power-up hold-off
  // ---------------------------------------------------------------
  // Supply must stay good for the power-up interval before access
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pwr_cnt_q  <= '0;
      pwr_good_q <= 1'b0;
    end
    else if (!ok_q)
    begin
      pwr_cnt_q  <= '0;
      pwr_good_q <= 1'b0;
    end
    else if (pwr_cnt_q >= 32'(POWERUP_CYCLES))
      pwr_good_q <= 1'b1;
    else
      pwr_cnt_q <= pwr_cnt_q + 32'd1;
  end

  // ---------------------------------------------------------------
  // Cycle timer
  // ---------------------------------------------------------------
  nvs_timer u_timer (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .tif     (tif)
  );

  // Timer load on each phase entry except recovery after a read
  always_comb
  begin
    tif.load  = 1'b0;
    tif.count = ONE_CNT;
    case (state_q)
      NVS_IDLE:
      begin
        tif.load  = req_valid && pwr_good_q;
        tif.count = ONE_CNT;
      end
      NVS_RD_SETUP:
      begin
        tif.load  = 1'b1;
        tif.count = RD_CNT;
      end
      NVS_WR_SETUP:
      begin
        tif.load  = 1'b1;
        tif.count = WR_CNT;
      end
      NVS_WR_PULSE:
      begin
        tif.load  = tif.done;
        tif.count = REC_CNT;
      end
      default:
      begin
        tif.load  = 1'b0;
        tif.count = ONE_CNT;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      state_q <= NVS_WAIT_PWR;
    else
      case (state_q)
        NVS_WAIT_PWR:
          if (pwr_good_q)
            state_q <= NVS_IDLE;
        NVS_IDLE:
          if (!pwr_good_q)
            state_q <= NVS_WAIT_PWR;
          else if (req_valid)
            state_q <= req_write ? NVS_WR_SETUP : NVS_RD_SETUP;
        NVS_RD_SETUP:
          state_q <= NVS_RD_WAIT;
        NVS_RD_WAIT:
          if (tif.done)
            state_q <= NVS_RECOVER;
        NVS_WR_SETUP:
          state_q <= NVS_WR_PULSE;
        NVS_WR_PULSE:
          if (tif.done)
            state_q <= NVS_RECOVER;
        NVS_RECOVER:
          if (tif.done)
            state_q <= NVS_IDLE;
        default:
          state_q <= NVS_WAIT_PWR;
      endcase
  end

  // ---------------------------------------------------------------
  // Request capture and address/data drive
  // ---------------------------------------------------------------
  // Address and write data stay fixed from setup to recovery
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      byte_addr    <= '0;
      byte_bus_out <= '0;
      wr_q         <= 1'b0;
    end
    else if (state_q == NVS_IDLE && req_valid && pwr_good_q)
    begin
      byte_addr    <= req_addr;
      byte_bus_out <= req_wdata;
      wr_q         <= req_write;
    end
  end

  // ---------------------------------------------------------------
  // Control strobes
  // ---------------------------------------------------------------
  // Select and strobe fall together and rise together; in reads the gate rises first
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      select_n       <= 1'b1;
      write_strobe_n <= 1'b1;
      output_gate_n  <= 1'b1;
      byte_bus_oe    <= 1'b0;
    end
    else
    begin
      select_n       <= !(state_q == NVS_RD_SETUP || state_q == NVS_RD_WAIT ||
                          state_q == NVS_WR_SETUP ||
                          (state_q == NVS_WR_PULSE && !tif.done));
      write_strobe_n <= !(state_q == NVS_WR_SETUP ||
                          (state_q == NVS_WR_PULSE && !tif.done));
      output_gate_n  <= !(state_q == NVS_RD_SETUP ||
                          (state_q == NVS_RD_WAIT && !tif.done));
      byte_bus_oe    <= (state_q == NVS_WR_SETUP) || (state_q == NVS_WR_PULSE) ||
                        (state_q == NVS_RECOVER && wr_q);
    end
  end

  // ---------------------------------------------------------------
  // Request handshake and read return
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end
    else
    begin
      req_ready <= (state_q == NVS_RECOVER && tif.done && pwr_good_q) ||
                   (state_q == NVS_WAIT_PWR && pwr_good_q) ||
                   (state_q == NVS_IDLE && !req_valid && pwr_good_q);
      rsp_valid <= (state_q == NVS_RECOVER && tif.done && !wr_q);
      if (state_q == NVS_RECOVER && !wr_q && req_ready == 1'b0 && tif.load == 1'b0
          && rsp_valid == 1'b0 && tif.done == 1'b0)
        rsp_rdata <= din_q;
      else if (state_q == NVS_RECOVER && !wr_q && tif.done)
        rsp_rdata <= din_q;
    end
  end

endmodule
`default_nettype wire

/* File: design/nvsram_pkg.sv */
/*
  Package for the host-side controller of a byte-wide battery-backed SRAM.
  Assumes a 20 MHz ref_clk; all timing figures are in nanoseconds.
*/
`default_nettype none
package nvsram_pkg;

  // ---------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int ACCESS_NS     = 200; // addr/select to data, slowest grade
  localparam int GATE_NS       = 100; // gate to data
  localparam int WRITE_NS      = 150; // write pulse width
  localparam int RECOVERY_NS   = 10;  // write recovery
  localparam int POWERUP_NS    = 2000000; // select high after power-up

  // Least times round up, never below one cycle
  localparam int ACCESS_CYC   = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GATE_CYC     = (GATE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_CYC    = (WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVERY_CYC = (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POWERUP_CYC  = (POWERUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int TMR_W = 16;

  // ---------------------------------------------------------------
  // Sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    NVS_WAIT_PWR = 3'b000,
    NVS_IDLE     = 3'b001,
    NVS_RD_SETUP = 3'b010,
    NVS_RD_WAIT  = 3'b011,
    NVS_WR_SETUP = 3'b100,
    NVS_WR_PULSE = 3'b101,
    NVS_RECOVER  = 3'b110
  } nvs_state_type;

endpackage
`default_nettype wire

/* File: design/nvs_tmr_if.sv */
/*
  Interface carrying the load/done handshake between sequencer and timer.
  Assumes both ends share ref_clk.
*/
`timescale 1ns/10ps
`default_nettype none
interface nvs_tmr_if;
  import nvsram_pkg::*;
  logic             load;
  logic [TMR_W-1:0] count;
  logic             done;
  modport ctl (output load, output count, input done);
  modport tmr (input load, input count, output done);
endinterface
`default_nettype wire

/* File: design/nvs_timer.sv */
/*
  Down-counter that flags completion of a loaded cycle count.
  Assumes load is a one-cycle pulse with count of at least one.
*/
`timescale 1ns/10ps
`default_nettype none
module nvs_timer
  import nvsram_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst_b,
  nvs_tmr_if.tmr    tif
);

  logic [TMR_W-1:0] cnt_q;

  // ---------------------------------------------------------------
  // Countdown
  // ---------------------------------------------------------------
  // Load wins over counting; done is high while count is zero
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      cnt_q <= '0;
    else if (tif.load)
      cnt_q <= tif.count;
    else if (cnt_q != '0)
      cnt_q <= cnt_q - 1'b1;
  end

  // Done looks only at the count, so a load that depends on done cannot loop
  assign tif.done = (cnt_q == '0);

endmodule
`default_nettype wire

/* File: tb/nvs_sram_model.sv */
/* Behavioural model of the byte-wide battery-backed SRAM.
   Assumes the host splits the data pins into out and enable. */
`timescale 1ns/10ps
`default_nettype none
module nvs_sram_model
(
  input  wire logic [nvsram_pkg::ADDR_W-1:0] byte_addr,
  input  wire logic                          select_n,
  input  wire logic                          write_strobe_n,
  input  wire logic                          output_gate_n,
  input  wire logic [nvsram_pkg::DATA_W-1:0] host_out,
  input  wire logic                          host_oe,
  input  wire logic                          supply_ok,
  output var  logic [nvsram_pkg::DATA_W-1:0] byte_bus
);
  import nvsram_pkg::*;
  // --------------------------------------------
  // Array and pins
  // --------------------------------------------
  logic [DATA_W-1:0] mem [8192];
  logic [DATA_W-1:0] last = '0;
  logic              rd;
  logic              rd_late;
  logic              wr;
  logic              drv;
  // Drive only once the access time has nearly run
  assign rd = write_strobe_n & ~select_n & ~output_gate_n & supply_ok;
  assign #(ACCESS_NS - 5) rd_late = rd;
  assign drv = rd & rd_late;
  assign wr = ~select_n & ~write_strobe_n;
  // Byte stored as the interval closes
  always @(negedge wr)
    if (supply_ok) mem[byte_addr] = host_oe ? host_out : ~host_out;
  // Released bus shows the inverse of its last value
  always @*
    if (host_oe) last = host_out;
    else if (drv) last = mem[byte_addr];
  assign byte_bus = host_oe ? host_out : (drv ? mem[byte_addr] : ~last);
endmodule
`default_nettype wire

/* File: tb/nvs_host_assertions.sv */
/* Pin sequencing checks for the SRAM host controller.
   Assumes it is bound into nvs_host. */
`timescale 1ns/10ps
`default_nettype none
module nvs_host_assertions
#(
  parameter int POWERUP_CYCLES = 8
)
(
  input  wire logic                          ref_clk,
  input  wire logic                          rst_b,
  input  wire logic                          supply_ok,
  input  wire logic [nvsram_pkg::ADDR_W-1:0] byte_addr,
  input  wire logic                          select_n,
  input  wire logic                          write_strobe_n,
  input  wire logic                          output_gate_n,
  input  wire logic [nvsram_pkg::DATA_W-1:0] byte_bus_out,
  input  wire logic                          byte_bus_oe
);
  import nvsram_pkg::*;
  // --------------------------------------------
  // Properties
  // --------------------------------------------
  logic [15:0] good_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // Cycles of good supply since reset or the last supply loss
  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b) good_q <= '0;
    else if (!supply_ok) good_q <= '0;
    else if (good_q != 16'hffff) good_q <= good_q + 16'h1;
  property p_addr; !select_n && !write_strobe_n && !$past(write_strobe_n) |-> $stable(byte_addr); endproperty
  a_addr: assert property (p_addr) else $error("address moved");
  property p_rec; $rose(write_strobe_n) |-> (write_strobe_n && select_n)[*2]; endproperty
  a_rec: assert property (p_rec) else $error("no recovery");
  property p_gate; !write_strobe_n |-> output_gate_n; endproperty
  a_gate: assert property (p_gate) else $error("gate low in write");
  property p_nodrv; !output_gate_n |-> !byte_bus_oe; endproperty
  a_nodrv: assert property (p_nodrv) else $error("bus clash");
  property p_setup; !write_strobe_n |-> byte_bus_oe && $stable(byte_bus_out); endproperty
  a_setup: assert property (p_setup) else $error("data not set up");
  property p_pwr; $fell(select_n) |-> good_q >= POWERUP_CYCLES; endproperty
  a_pwr: assert property (p_pwr) else $error("early access");
  property p_rd; $fell(output_gate_n) |-> (!select_n && !output_gate_n)[*4]; endproperty
  a_rd: assert property (p_rd) else $error("read too short");
  property p_wr; $fell(write_strobe_n) |-> (!select_n && !write_strobe_n)[*3]; endproperty
  a_wr: assert property (p_wr) else $error("write too short");
endmodule
bind nvs_host nvs_host_assertions #(.POWERUP_CYCLES(POWERUP_CYCLES)) u_chk (.ref_clk,
  .rst_b, .supply_ok, .byte_addr, .select_n, .write_strobe_n, .output_gate_n,
  .byte_bus_out, .byte_bus_oe);
`default_nettype wire

/* File: tb/nv_sram_byte_port_tb_top.sv */
/* Self-checking bench for the SRAM host controller.
   Assumes the behavioural SRAM model on the memory pins. */
`timescale 1ns/10ps
`default_nettype none
module nv_sram_byte_port_tb_top;
  import nvsram_pkg::*;
  // --------------------------------------------
  // Harness
  // --------------------------------------------
  typedef struct packed {logic [12:0] a; logic [7:0] d;} nvs_row_type;
  localparam nvs_row_type ROWS [4] = '{'{13'h0000, 8'h5a}, '{13'h1fff, 8'ha5},
                                      '{13'h0aaa, 8'h00}, '{13'h1555, 8'hff}};
  logic              ref_clk = 1'b0;
  logic              rst_b = 1'b0;
  logic              supply_ok = 1'b1;
  logic              req_valid = 1'b0;
  logic              req_write = 1'b0;
  logic [ADDR_W-1:0] req_addr = '0;
  logic [DATA_W-1:0] req_wdata = '0;
  logic [DATA_W-1:0] rsp_rdata, byte_bus_out, byte_bus_in;
  logic [ADDR_W-1:0] byte_addr;
  logic              req_ready, rsp_valid, select_n, write_strobe_n, output_gate_n, byte_bus_oe;
  int                miscompares = 0;
  int                n_tests = 0;
  always #25 ref_clk = ~ref_clk;
  nvs_host #(.POWERUP_CYCLES(8)) DUT (.ref_clk, .rst_b, .supply_ok, .req_valid, .req_write,
    .req_addr, .req_wdata, .req_ready, .rsp_valid, .rsp_rdata, .byte_addr, .select_n,
    .write_strobe_n, .output_gate_n, .byte_bus_in, .byte_bus_out, .byte_bus_oe);
  nvs_sram_model u_mem (.byte_addr, .select_n, .write_strobe_n, .output_gate_n,
    .host_out(byte_bus_out), .host_oe(byte_bus_oe), .supply_ok, .byte_bus(byte_bus_in));
  task automatic stop_test();
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h0, got}, {7'h0, exp});
  endtask
  // Bounded wait for an idle controller
  task automatic wait_ready();
    int n;
    n = 0;
    #1;
    while (req_ready !== 1'b1 && n < 200)
    begin
      @(posedge ref_clk);
      #1 n++;
    end
    if (n == 200) miscompares++;
  endtask
  task automatic xfer(input logic w, input logic [12:0] a, input logic [7:0] d);
    wait_ready();
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    @(posedge ref_clk);
    req_valid <= 1'b0;
  endtask
  task automatic rd_chk(input logic [12:0] a, input logic [7:0] exp);
    int n;
    xfer(1'b0, a, 8'h00);
    n = 0;
    while (rsp_valid !== 1'b1 && n < 40)
    begin
      @(posedge ref_clk);
      #1 n++;
    end
    chk1(rsp_valid, 1'b1);
    chk8(rsp_rdata, exp);
  endtask
  // Watchdog
  initial
  begin
    #(CLK_PERIOD_NS * 5000);
    miscompares++;
    stop_test();
  end
  // Main sequence
  initial
  begin
    repeat (4) @(posedge ref_clk);
    #1 chk1(req_ready, 1'b0);
    chk1(byte_bus_oe, 1'b0);
    @(posedge ref_clk);
    rst_b <= 1'b1;
    foreach (ROWS[i]) xfer(1'b1, ROWS[i].a, ROWS[i].d);
    foreach (ROWS[i]) rd_chk(ROWS[i].a, ROWS[i].d);
    xfer(1'b1, 13'h0000, 8'hc3);
    rd_chk(13'h0000, 8'hc3);
    // Supply loss with a request held waiting
    @(posedge ref_clk);
    supply_ok <= 1'b0;
    repeat (4) @(posedge ref_clk);
    #1 chk1(req_ready, 1'b0);
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_write <= 1'b1;
    req_addr <= 13'h1fff;
    req_wdata <= 8'h11;
    repeat (20)
    begin
      @(posedge ref_clk);
      #1 chk1(select_n, 1'b1);
    end
    @(posedge ref_clk);
    supply_ok <= 1'b1;
    wait_ready();
    @(posedge ref_clk);
    req_valid <= 1'b0;
    rd_chk(13'h1fff, 8'h11);
    rd_chk(13'h1555, 8'hff);
    // Second reset in mid-run keeps contents
    @(posedge ref_clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 chk1(select_n, 1'b1);
    @(posedge ref_clk);
    rst_b <= 1'b1;
    rd_chk(13'h0aaa, 8'h00);
    stop_test();
  end
endmodule
`default_nettype wire
